// File: ebp_cfg.svh
`ifndef EBP_CFG_SVH
`define EBP_CFG_SVH

// register byte offsets
`define EBP_OFF_CMD      12'h000
`define EBP_OFF_BLOCK    12'h004
`define EBP_OFF_PW0      12'h008
`define EBP_OFF_PW1      12'h00C
`define EBP_OFF_PW2      12'h010
`define EBP_OFF_PWCNT    12'h014
`define EBP_OFF_PROT     12'h018
`define EBP_OFF_STATUS   12'h01C
`define EBP_OFF_RESULT   12'h020
`define EBP_OFF_ACCADDR  12'h024
`define EBP_OFF_ACCCTL   12'h028
`define EBP_OFF_GEOM     12'h02C

// store geometry
`define EBP_NUM_BLOCKS   16
`define EBP_BLK_BITS     4
`define EBP_STORE_BYTES  2048
`define EBP_BLK_BYTES    (`EBP_STORE_BYTES / `EBP_NUM_BLOCKS)
`define EBP_ADDR_BITS    11
`define EBP_BLK_SHIFT    7

// status bit positions
`define EBP_ST_RDBUSY    0
`define EBP_ST_NOPERM    1
`define EBP_ST_WKCOPY    2
`define EBP_ST_WKERASE   3
`define EBP_ST_WORKING   4

// protection field: bits 1:0 level, bit 3 privileged
`define EBP_PROT_PRIV    3

// access control bits
`define EBP_ACC_WRITE    0
`define EBP_ACC_USER     1

// write engine busy time
`define EBP_WRITE_NS     80
`define EBP_CLK_NS       10
`define EBP_WRITE_CYC    (`EBP_WRITE_NS / `EBP_CLK_NS)

`define EBP_ERASED       32'hFFFFFFFF

`endif

// File: ebp_pkg.sv
package ebp_pkg;
  typedef enum logic [2:0] {
    EBP_CMD_NONE   = 3'h0,
    EBP_CMD_HIDE   = 3'h1,
    EBP_CMD_LOCK   = 3'h2,
    EBP_CMD_UNLOCK = 3'h3,
    EBP_CMD_SETPW  = 3'h4,
    EBP_CMD_SETPRT = 3'h5,
    EBP_CMD_GETPRT = 3'h6,
    EBP_CMD_ACCESS = 3'h7
  } ebp_cmd_type;

  typedef enum logic [1:0] {
    EBP_LVL_RW_LRO = 2'h0,
    EBP_LVL_NA     = 2'h1,
    EBP_LVL_RO     = 2'h2
  } ebp_level_type;

  typedef enum logic [1:0] {
    EBP_ST_IDLE  = 2'b00,
    EBP_ST_WRITE = 2'b01,
    EBP_ST_DONE  = 2'b11
  } ebp_state_type;
endpackage

// File: ebp_top.sv
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "ebp_cfg.svh"
// How it works
// - a read attempted while a write runs sets the read-during-write flag
// - addresses are zero-based byte offsets; block start is block times size
// - every block has the same size: store bytes over block count
// - any block but 0 can be hidden; hidden blocks refuse access, password set and protection set until reset
// - lock only takes effect on blocks that already have a password
// - after lock or unlock, result is 1 when unlocked, 0 when locked
// - while block 0 is locked every other block is denied
// - a password is accepted once; later sets fail with no-permission
// - new password leaves block unlocked until a lock of it or block 0
// - with block 0 unlocked, blocks follow their own lock and level
// - protection set assumes none written before; it simply overwrites
// - blocks 1 and up use block 0 flags ORed with their own
// - privileged-only flag denies user accesses, else all allowed
// - read-write level: full when no password or unlocked, read if locked
// - no-access level: nothing unless password set and unlocked
// - read-only level: read when no password or unlocked, none if locked
// - unlock succeeds only if the word count and all supplied words match stored ones
// - password and protection set return the five-bit status word
// - refused writes set the no-permission flag
module ebp_top
  import ebp_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // access verdict for the store behind
  output logic             access_grant_ff
);

  localparam int NB = `EBP_NUM_BLOCKS;

  // ----------------------------------------------------------------
  // protection state
  // ----------------------------------------------------------------
  logic [31:0]          pw_ff [NB][3];
  logic [1:0]           pwcnt_ff [NB];
  logic [NB-1:0]        haspw_ff;
  logic [NB-1:0]        locked_ff;
  logic [NB-1:0]        hidden_ff;
  logic [3:0]           prot_ff [NB];

  // software-visible parameter registers and engine state
  logic [`EBP_BLK_BITS-1:0] blk_ff;
  logic [31:0]          pwin_ff [3];
  logic [1:0]           pwincnt_ff;
  logic [3:0]           protin_ff;
  logic [`EBP_ADDR_BITS-1:0] accaddr_ff;
  logic [1:0]           accctl_ff;
  logic [4:0]           status_ff;
  logic [3:0]           result_ff;
  ebp_state_type        state_ff;
  logic [3:0]           wcnt_ff;

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic        wr_go;
  logic [2:0]  cmd_go;
  logic        cmd_fire;

  assign wr_go = aw_hold_ff && w_hold_ff;
  assign cmd_fire = wr_go && awaddr_ff == `EBP_OFF_CMD;
  assign cmd_go = wdata_ff[2:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_ff   <= 1'b0;
      w_hold_ff    <= 1'b0;
      awaddr_ff    <= 12'h000;
      wdata_ff     <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff    <= 1'b1;
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff    <= 1'b1;
        wdata_ff     <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff > `EBP_OFF_GEOM) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // access decision
  // ----------------------------------------------------------------
  logic [`EBP_BLK_BITS-1:0] acc_blk;
  logic [3:0] eff_prot;
  logic       acc_rd_ok;
  logic       acc_wr_ok;
  logic       open_blk;
  logic       gate_ok;

  assign acc_blk = accaddr_ff[`EBP_ADDR_BITS-1:`EBP_BLK_SHIFT];

  always_comb begin
    eff_prot = (acc_blk != '0) ? (prot_ff[acc_blk] | prot_ff[0]) : prot_ff[acc_blk];
    open_blk = !haspw_ff[acc_blk] || !locked_ff[acc_blk];
    gate_ok = (acc_blk == '0) || !haspw_ff[0] || !locked_ff[0];
    acc_rd_ok = 1'b0;
    acc_wr_ok = 1'b0;
    case (eff_prot[1:0])
      EBP_LVL_RW_LRO: begin
        acc_rd_ok = 1'b1;
        acc_wr_ok = open_blk;
      end
      EBP_LVL_NA: begin
        acc_rd_ok = haspw_ff[acc_blk] && !locked_ff[acc_blk];
        acc_wr_ok = acc_rd_ok;
      end
      default: begin
        acc_rd_ok = open_blk;
      end
    endcase
    if ((eff_prot[`EBP_PROT_PRIV] && accctl_ff[`EBP_ACC_USER]) ||
        hidden_ff[acc_blk] || !gate_ok) begin
      acc_rd_ok = 1'b0;
      acc_wr_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  logic pw_match;
  logic busy;

  assign busy = state_ff == EBP_ST_WRITE;

  always_comb begin
    pw_match = pwincnt_ff == pwcnt_ff[blk_ff];
    for (int i = 0; i < 3; i++) begin
      if (i < int'(pwincnt_ff) && pwin_ff[i] != pw_ff[blk_ff][i]) begin
        pw_match = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hidden_ff <= '0;
      locked_ff <= '1; // only matters where a password exists
      haspw_ff  <= '0;
      pwcnt_ff  <= '{default: 2'h0};
      prot_ff   <= '{default: 4'h0};
      pw_ff     <= '{default: 32'h00000000};
      result_ff       <= 4'h0;
      status_ff       <= 5'h00;
      state_ff        <= EBP_ST_IDLE;
      wcnt_ff         <= 4'h0;
      access_grant_ff <= 1'b0;
    end else begin
      case (state_ff)
        EBP_ST_WRITE: begin
          status_ff[`EBP_ST_WORKING] <= 1'b1;
          if (wcnt_ff == 4'h1) begin
            state_ff <= EBP_ST_DONE;
          end
          wcnt_ff <= wcnt_ff - 4'h1;
        end
        EBP_ST_DONE: begin
          status_ff[`EBP_ST_WORKING] <= 1'b0;
          state_ff <= EBP_ST_IDLE;
        end
        default: state_ff <= EBP_ST_IDLE;
      endcase
      if (cmd_fire) begin
        case (cmd_go)
          EBP_CMD_HIDE: begin
            if (blk_ff != '0) begin
              hidden_ff[blk_ff] <= 1'b1;
            end
          end
          EBP_CMD_LOCK: begin
            if (haspw_ff[blk_ff] && blk_ff == '0) begin
              locked_ff <= '1;
            end else if (haspw_ff[blk_ff]) begin
              locked_ff[blk_ff] <= 1'b1;
            end
            result_ff <= {3'h0, !haspw_ff[blk_ff]};
          end
          EBP_CMD_UNLOCK: begin
            if (pw_match) begin
              locked_ff[blk_ff] <= 1'b0;
            end
            result_ff <= {3'h0, !haspw_ff[blk_ff] || pw_match ||
                          !locked_ff[blk_ff]};
          end
          EBP_CMD_SETPW: begin
            status_ff <= 5'h00;
            if (busy) begin
              status_ff[`EBP_ST_WORKING] <= 1'b1;
            end else if (haspw_ff[blk_ff] || hidden_ff[blk_ff]) begin
              status_ff[`EBP_ST_NOPERM] <= 1'b1;
            end else begin
              haspw_ff[blk_ff]  <= 1'b1;
              locked_ff[blk_ff] <= 1'b0;
              pwcnt_ff[blk_ff]  <= pwincnt_ff;
              pw_ff[blk_ff]     <= pwin_ff;
              state_ff <= EBP_ST_WRITE;
              wcnt_ff  <= 4'(`EBP_WRITE_CYC);
            end
          end
          EBP_CMD_SETPRT: begin
            status_ff <= 5'h00;
            if (busy) begin
              status_ff[`EBP_ST_WORKING] <= 1'b1;
            end else if (hidden_ff[blk_ff] ||
                         (haspw_ff[blk_ff] && locked_ff[blk_ff]) ||
                         (blk_ff != '0 && locked_ff[0] && haspw_ff[0])) begin
              status_ff[`EBP_ST_NOPERM] <= 1'b1;
            end else begin
              prot_ff[blk_ff] <= protin_ff;
              state_ff <= EBP_ST_WRITE;
              wcnt_ff  <= 4'(`EBP_WRITE_CYC);
            end
          end
          EBP_CMD_GETPRT: begin
            result_ff <= prot_ff[blk_ff];
          end
          EBP_CMD_ACCESS: begin
            if (accctl_ff[`EBP_ACC_WRITE]) begin
              if (busy) begin
                status_ff[`EBP_ST_WORKING] <= 1'b1;
                access_grant_ff <= 1'b0;
              end else begin
                access_grant_ff <= acc_wr_ok;
                status_ff[`EBP_ST_NOPERM] <= !acc_wr_ok;
                if (acc_wr_ok) begin
                  state_ff <= EBP_ST_WRITE;
                  wcnt_ff  <= 4'(`EBP_WRITE_CYC);
                end
              end
            end else begin
              access_grant_ff <= acc_rd_ok && !busy;
              status_ff[`EBP_ST_RDBUSY] <= busy;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      blk_ff     <= '0;
      pwincnt_ff <= 2'h1;
      protin_ff  <= 4'h0;
      accaddr_ff <= '0;
      accctl_ff  <= 2'h0;
      pwin_ff    <= '{default: 32'h00000000};
    end else if (wr_go) begin
      if (awaddr_ff == `EBP_OFF_BLOCK) begin
        blk_ff <= wdata_ff[`EBP_BLK_BITS-1:0];
      end else if (awaddr_ff == `EBP_OFF_PW0) begin
        pwin_ff[0] <= wdata_ff;
      end else if (awaddr_ff == `EBP_OFF_PW1) begin
        pwin_ff[1] <= wdata_ff;
      end else if (awaddr_ff == `EBP_OFF_PW2) begin
        pwin_ff[2] <= wdata_ff;
      end else if (awaddr_ff == `EBP_OFF_PWCNT) begin
        pwincnt_ff <= wdata_ff[1:0];
      end else if (awaddr_ff == `EBP_OFF_PROT) begin
        protin_ff <= wdata_ff[3:0];
      end else if (awaddr_ff == `EBP_OFF_ACCADDR) begin
        accaddr_ff <= wdata_ff[`EBP_ADDR_BITS-1:0];
      end else if (awaddr_ff == `EBP_OFF_ACCCTL) begin
        accctl_ff <= wdata_ff[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_bad;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_bad = s_axi_araddr > `EBP_OFF_GEOM;
    if (s_axi_araddr == `EBP_OFF_BLOCK) begin
      rd_mux = {28'h0000000, blk_ff};
    end else if (s_axi_araddr == `EBP_OFF_PWCNT) begin
      rd_mux = {30'h00000000, pwincnt_ff};
    end else if (s_axi_araddr == `EBP_OFF_PROT) begin
      rd_mux = {28'h0000000, protin_ff};
    end else if (s_axi_araddr == `EBP_OFF_STATUS) begin
      rd_mux = {27'h0000000, status_ff};
    end else if (s_axi_araddr == `EBP_OFF_RESULT) begin
      rd_mux = {28'h0000000, result_ff};
    end else if (s_axi_araddr == `EBP_OFF_ACCADDR) begin
      rd_mux = {21'h000000, accaddr_ff};
    end else if (s_axi_araddr == `EBP_OFF_ACCCTL) begin
      rd_mux = {30'h00000000, accctl_ff};
    end else if (s_axi_araddr == `EBP_OFF_GEOM) begin
      rd_mux = {16'(`EBP_STORE_BYTES), 16'(`EBP_NUM_BLOCKS)};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_bad ? 2'h2 : 2'h0;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_HIDE_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    !hidden_ff[0]) else $error("block 0 hidden");
  AST_SETPW_UNLOCK: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_fire && cmd_go == EBP_CMD_SETPW && !busy && !haspw_ff[blk_ff]
    && !hidden_ff[blk_ff] |=> !locked_ff[$past(blk_ff)] && haspw_ff[$past(blk_ff)])
    else $error("new password not unlocked");
  AST_SETPW_TWICE: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_fire && cmd_go == EBP_CMD_SETPW && !busy && haspw_ff[blk_ff]
    |=> status_ff[`EBP_ST_NOPERM]) else $error("second password not flagged");
  AST_LOCK_NOPW: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_fire && cmd_go == EBP_CMD_LOCK && !haspw_ff[blk_ff]
    |=> result_ff == 4'h1) else $error("lock without password not reported");
  AST_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    acc_blk != '0 && locked_ff[0] && haspw_ff[0] |-> !acc_rd_ok && !acc_wr_ok)
    else $error("access through locked block 0");
  AST_USER: assert property (@(posedge ref_clk) disable iff (rst)
    eff_prot[`EBP_PROT_PRIV] && accctl_ff[`EBP_ACC_USER] |-> !acc_rd_ok)
    else $error("user access to privileged block");
  AST_RDBUSY: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_fire && cmd_go == EBP_CMD_ACCESS && !accctl_ff[0] && busy
    |=> status_ff[`EBP_ST_RDBUSY] && !access_grant_ff)
    else $error("read during write missed");
  AST_WORK_LEN: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(status_ff[`EBP_ST_WORKING]) && !cmd_fire |-> ##[1:9] !busy)
    else $error("engine stays busy too long");
endmodule

// File: ebp_host.sv
`timescale 1ns/1ns
module ebp_host (
  // clock
  input  wire logic        ref_clk,
  // write address and data
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  // write response
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // each channel dropped at the edge where its own ready is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ns
`include "ebp_cfg.svh"
module tb
  import ebp_pkg::*;
;
  logic        ref_clk, rst;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, grant;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ebp_top uut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .access_grant_ff(grant));

  ebp_host host (.ref_clk(ref_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic summarize;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // whole run needs about a thousand cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // access helpers
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.wr(a, d, resp);
  endtask

  task automatic rd(input logic [11:0] a);
    host.rd(a, rdat, resp);
  endtask

  task automatic cmd(input int b, input ebp_cmd_type c);
    wr(`EBP_OFF_BLOCK, 32'(b));
    wr(`EBP_OFF_CMD, 32'(c));
  endtask

  task automatic idle;
    do rd(`EBP_OFF_STATUS); while (rdat[`EBP_ST_WORKING] !== 1'b0);
  endtask

  task automatic lock_res(input logic e);
    rd(`EBP_OFF_RESULT);
    chk1(rdat[0], e);
  endtask

  // grant is a level, so two edges leave it settled
  task automatic acc(input int b, input logic wrt, input logic usr, input logic e);
    wr(`EBP_OFF_ACCADDR, 32'(b * `EBP_BLK_BYTES + 4));
    wr(`EBP_OFF_ACCCTL, {30'h0, usr, wrt});
    wr(`EBP_OFF_CMD, 32'(EBP_CMD_ACCESS));
    repeat (2) @(posedge ref_clk);
    chk1(grant, e);
    idle();
  endtask

  // never the erased pattern
  function automatic logic [31:0] pwd(input int b, input int i);
    return 32'hA5C30000 | 32'(b << 4) | 32'(i);
  endfunction

  task automatic setpw(input int b, input int n);
    for (int i = 0; i < 3; i++) wr(`EBP_OFF_PW0 + 12'(4 * i), pwd(b, i));
    wr(`EBP_OFF_PWCNT, 32'(n));
    cmd(b, EBP_CMD_SETPW);
  endtask

  task automatic unl(input int b, input int n, input logic good);
    for (int i = 0; i < 3; i++) wr(`EBP_OFF_PW0 + 12'(4 * i), pwd(b, i) ^ {31'h0, !good});
    wr(`EBP_OFF_PWCNT, 32'(n));
    cmd(b, EBP_CMD_UNLOCK);
  endtask

  task automatic prot(input int b, input logic [31:0] p);
    wr(`EBP_OFF_PROT, p);
    cmd(b, EBP_CMD_SETPRT);
    idle();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`EBP_OFF_GEOM);
    chk32(rdat, {16'(`EBP_STORE_BYTES), 16'(`EBP_NUM_BLOCKS)});
    rd(12'h030);
    chk32(32'(resp), 32'h2);
    host.wr(12'h030, 32'h0, resp);
    chk32(32'(resp), 32'h2);
    // read attempted while a write is still running
    wr(`EBP_OFF_ACCADDR, 32'(`EBP_BLK_BYTES));
    wr(`EBP_OFF_ACCCTL, 32'h1);
    wr(`EBP_OFF_CMD, 32'(EBP_CMD_ACCESS));
    wr(`EBP_OFF_ACCCTL, 32'h0);
    wr(`EBP_OFF_CMD, 32'(EBP_CMD_ACCESS));
    rd(`EBP_OFF_STATUS);
    chk1(rdat[`EBP_ST_RDBUSY], 1'b1);
    idle();
    acc(1, 1'b1, 1'b0, 1'b1);
    setpw(1, 1);
    rd(`EBP_OFF_STATUS);
    chk32(rdat & 32'h1F, 32'h10);
    idle();
    acc(1, 1'b1, 1'b0, 1'b1);
    setpw(1, 1);
    rd(`EBP_OFF_STATUS);
    chk1(rdat[`EBP_ST_NOPERM], 1'b1);
    cmd(1, EBP_CMD_LOCK);
    lock_res(1'b0);
    cmd(2, EBP_CMD_LOCK);
    lock_res(1'b1);
    acc(1, 1'b0, 1'b0, 1'b1);
    acc(1, 1'b1, 1'b0, 1'b0);
    rd(`EBP_OFF_STATUS);
    chk1(rdat[`EBP_ST_NOPERM], 1'b1);
    unl(1, 1, 1'b1);
    prot(1, 32'(EBP_LVL_NA));
    cmd(1, EBP_CMD_LOCK);
    acc(1, 1'b0, 1'b0, 1'b0);
    unl(1, 1, 1'b1);
    prot(1, 32'(EBP_LVL_RO));
    cmd(1, EBP_CMD_LOCK);
    prot(1, 32'(EBP_LVL_RW_LRO));
    rd(`EBP_OFF_STATUS);
    chk1(rdat[`EBP_ST_NOPERM], 1'b1);
    acc(1, 1'b0, 1'b0, 1'b0);
    unl(1, 1, 1'b0);
    lock_res(1'b0);
    unl(1, 2, 1'b1);
    lock_res(1'b0);
    unl(1, 1, 1'b1);
    lock_res(1'b1);
    acc(1, 1'b0, 1'b0, 1'b1);
    acc(1, 1'b1, 1'b0, 1'b0);
    prot(1, 32'(EBP_LVL_NA));
    acc(1, 1'b0, 1'b0, 1'b1);
    acc(1, 1'b1, 1'b0, 1'b1);
    prot(3, 32'h8);
    acc(3, 1'b0, 1'b1, 1'b0);
    acc(3, 1'b0, 1'b0, 1'b1);
    cmd(3, EBP_CMD_GETPRT);
    rd(`EBP_OFF_RESULT);
    chk32(rdat & 32'hF, 32'h8);
    setpw(0, 3);
    idle();
    setpw(5, 2);
    idle();
    cmd(0, EBP_CMD_LOCK);
    lock_res(1'b0);
    acc(2, 1'b0, 1'b0, 1'b0);
    unl(0, 3, 1'b1);
    lock_res(1'b1);
    acc(2, 1'b1, 1'b0, 1'b1);
    acc(5, 1'b1, 1'b0, 1'b0);
    prot(0, 32'h8);
    acc(4, 1'b0, 1'b1, 1'b0);
    acc(4, 1'b0, 1'b0, 1'b1);
    prot(0, 32'(EBP_LVL_RO));
    acc(4, 1'b1, 1'b0, 1'b0);
    cmd(6, EBP_CMD_HIDE);
    acc(6, 1'b0, 1'b0, 1'b0);
    cmd(0, EBP_CMD_HIDE);
    acc(0, 1'b0, 1'b0, 1'b1);
    // second reset in mid-run
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    acc(6, 1'b0, 1'b0, 1'b1);
    summarize();
  end
endmodule
